// *** verilog/scps_regs.svh ***
`ifndef SCPS_REGS_SVH
`define SCPS_REGS_SVH

// ----------------------------------------------------------------------
// Storage array
// ----------------------------------------------------------------------
`define SCPS_ARRAY_BITS      65536
`define SCPS_ADDR_W          16
`define SCPS_LAST_ADDR       16'hffff
`define SCPS_FIFO_DEPTH      8

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define SCPS_CLK_PERIOD_NS   10
`define SCPS_OSC_PERIOD_NS   80
`define SCPS_OSC_HALF_CYC    ((`SCPS_OSC_PERIOD_NS / `SCPS_CLK_PERIOD_NS) / 2)
`define SCPS_TAIL_CLOCKS     16
`define SCPS_TAIL_LAST       4'hf
`define SCPS_CHAIN_LIMIT     20'h30000

`endif

// *** verilog/scps_pkg.sv ***
package scps_pkg;

  // --------------------------------------------------------------------
  // Sequencer states, Gray along reset-hold-run-cascade-tail-sleep
  // --------------------------------------------------------------------
  typedef enum logic [2:0] {
    SCPS_RESET = 3'h0,
    SCPS_HOLD  = 3'h1,
    SCPS_RUN   = 3'h3,
    SCPS_CASC  = 3'h2,
    SCPS_TAIL  = 3'h6,
    SCPS_SLEEP = 3'h7,
    SCPS_ERROR = 3'h5
  } scps_state_t;

  // --------------------------------------------------------------------
  // Carriers
  // --------------------------------------------------------------------
  typedef struct packed {
    logic out;
    logic oe;
  } scps_pad_t;

  typedef struct packed {
    logic master;
    logic newer;
  } scps_mode_t;

endpackage : scps_pkg

// *** verilog/scps_streamer.sv ***
// Operation
// - Reset input low clears address counter and floats data output.
// - Select high after reset keeps counter frozen and data floating.
// - Select low with reset released enables counter and data drive.
// - Any new reset low clears counter and floats data whatever select is.
// - Rising reset input latches operating mode and target protocol.
// - After last bit, cascade output goes low and data output floats.
// - Power-up clears address counter without an external reset pulse.
// - Reset input gates the oscillator and the counter; select gates both except during the 16 tail clocks.
// - Newer protocol master shifts bits out on own oscillator, driven on clock pin.
// - Device leaving reset with select low is master, supplying all clocks under newer protocol.
// - Exhausted memory drives cascade low, enabling next memory via its select.
// - Master keeps clocking downstream memories until configuration is complete.
// - After select rises on complete transfer, master gives 16 clocks, then idles.
// - Select rising before all data sent makes master pull status low.
// - Select staying low after all data sent makes master pull status low.
// - Array is one bit wide, read one bit per clock.
// - Rising clock advances counter and next bit only when enabled and data remains.
// - Cascade output goes low on the rising clock after counter reaches its maximum.
// - Master clock pin drives low after completion or while reset is low.
// - Device reset with select high initialises as subsequent chain member.
`timescale 1ns/1ps
`include "scps_regs.svh"
`default_nettype none

// ----------------------------------------------------------------------
// Bit FIFO between array and serial output
// ----------------------------------------------------------------------
module scps_fifo #(
  parameter int W = 1,
  parameter int D = 8
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         clr,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic      [W-1:0] out_data
);
  localparam int AW = $clog2(D);

  logic [W-1:0] mem_q [D];
  logic [AW:0]  wr_ptr_ff;
  logic [AW:0]  rd_ptr_ff;
  wire          full;
  wire          empty;
  wire          push;
  wire          pop;

  assign full      = (wr_ptr_ff[AW] != rd_ptr_ff[AW]) &&
                     (wr_ptr_ff[AW-1:0] == rd_ptr_ff[AW-1:0]);
  assign empty     = (wr_ptr_ff == rd_ptr_ff);
  assign in_ready  = ~full & ~clr;
  assign out_valid = ~empty & ~clr;
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  assign out_data  = mem_q[rd_ptr_ff[AW-1:0]];

  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_ptr_ff[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
    end else if (clr) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
    end else begin
      wr_ptr_ff <= wr_ptr_ff + (AW+1)'(push);
      rd_ptr_ff <= rd_ptr_ff + (AW+1)'(pop);
    end
  end
endmodule : scps_fifo

// ----------------------------------------------------------------------
// Serial configuration memory streamer
// ----------------------------------------------------------------------
module scps_streamer #(
  parameter logic [19:0] CHAIN_LIMIT = `SCPS_CHAIN_LIMIT
) (
  input  wire logic                    clk,
  input  wire logic                    rst,
  input  wire logic                    oe_rst_pin,
  input  wire logic                    select_n,
  input  wire logic                    protocol_newer,
  input  wire logic                    config_clock_in,
  output scps_pkg::scps_pad_t          config_clock,
  output scps_pkg::scps_pad_t          target_serial_in,
  output logic                         cascade_out_n,
  output scps_pkg::scps_pad_t          target_status_n,
  input  wire logic                    prog_we,
  input  wire logic [`SCPS_ADDR_W-1:0] prog_addr,
  input  wire logic                    prog_bit
);
  localparam logic [2:0] OSC_LAST = 3'(`SCPS_OSC_HALF_CYC - 1);

  // --------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------
  logic [3:0] sync1_ff;
  logic [3:0] sync2_ff;
  logic       oe_d_ff;
  logic       ext_clk_d_ff;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync1_ff <= 4'h0;
      sync2_ff <= 4'h0;
    end else begin
      sync1_ff <= {protocol_newer, config_clock_in, select_n, oe_rst_pin};
      sync2_ff <= sync1_ff;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      oe_d_ff      <= 1'b0;
      ext_clk_d_ff <= 1'b0;
    end else begin
      oe_d_ff      <= sync2_ff[0];
      ext_clk_d_ff <= sync2_ff[2];
    end
  end

  wire oe_s       = sync2_ff[0];
  wire sel_n_s    = sync2_ff[1];
  wire ext_clk_s  = sync2_ff[2];
  wire newer_s    = sync2_ff[3];
  wire oe_rise    = oe_s & ~oe_d_ff;
  wire ext_rise   = ext_clk_s & ~ext_clk_d_ff;
  wire active     = oe_s & ~sel_n_s;

  // --------------------------------------------------------------------
  // Mode latch
  // --------------------------------------------------------------------
  scps_pkg::scps_mode_t  mode_ff;
  scps_pkg::scps_state_t state_ff;
  scps_pkg::scps_state_t nxt_state;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mode_ff <= '0;
    end else if (oe_rise) begin
      mode_ff <= '{master: ~sel_n_s, newer: newer_s};
    end
  end

  wire drive_clk = mode_ff.master & mode_ff.newer;

  // --------------------------------------------------------------------
  // Internal oscillator
  // --------------------------------------------------------------------
  logic [2:0] osc_div_ff;
  logic       osc_ff;
  wire        in_run   = (state_ff == scps_pkg::SCPS_RUN);
  wire        in_casc  = (state_ff == scps_pkg::SCPS_CASC);
  wire        in_tail  = (state_ff == scps_pkg::SCPS_TAIL);
  wire        osc_run  = drive_clk & oe_s &
                         (((in_run | in_casc) & active) | in_tail);
  wire        osc_wrap = osc_run & (osc_div_ff == OSC_LAST);
  wire        osc_rise = osc_wrap & ~osc_ff;
  wire        rise     = drive_clk ? osc_rise : ext_rise;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      osc_div_ff <= 3'h0;
      osc_ff     <= 1'b0;
    end else if (!osc_run) begin
      osc_div_ff <= 3'h0;
      osc_ff     <= 1'b0;
    end else begin
      osc_div_ff <= osc_wrap ? 3'h0 : osc_div_ff + 3'h1;
      osc_ff     <= osc_wrap ? ~osc_ff : osc_ff;
    end
  end

  // --------------------------------------------------------------------
  // Storage array and prefetch
  // --------------------------------------------------------------------
  logic                    array_q [`SCPS_ARRAY_BITS];
  logic [`SCPS_ADDR_W:0]   rd_addr_ff;
  wire                     fill_valid = oe_s & ~rd_addr_ff[`SCPS_ADDR_W];
  wire                     fill_ready;
  wire                     fill_bit   = array_q[rd_addr_ff[`SCPS_ADDR_W-1:0]];
  wire                     buf_valid;
  wire                     buf_bit;
  wire                     buf_pop;

  always_ff @(posedge clk) begin
    if (prog_we) begin
      array_q[prog_addr] <= prog_bit;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_addr_ff <= '0;
    end else if (!oe_s) begin
      rd_addr_ff <= '0;
    end else if (fill_valid && fill_ready) begin
      rd_addr_ff <= rd_addr_ff + (`SCPS_ADDR_W+1)'(1);
    end
  end

  scps_fifo #(
    .W (1),
    .D (`SCPS_FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rst       (rst),
    .clr       (~oe_s),
    .in_valid  (fill_valid),
    .in_ready  (fill_ready),
    .in_data   (fill_bit),
    .out_valid (buf_valid),
    .out_ready (buf_pop),
    .out_data  (buf_bit)
  );

  // --------------------------------------------------------------------
  // Address counter and output bit
  // --------------------------------------------------------------------
  logic [`SCPS_ADDR_W-1:0] bit_addr_ff;
  logic                    loaded_ff;
  logic                    data_ff;
  wire                     last_bit = (bit_addr_ff == `SCPS_LAST_ADDR);
  wire                     want     = in_run & active &
                                      (~loaded_ff | (rise & ~last_bit));
  assign buf_pop = want & buf_valid;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bit_addr_ff <= '0;
      loaded_ff   <= 1'b0;
      data_ff     <= 1'b0;
    end else if (!oe_s) begin
      bit_addr_ff <= '0;
      loaded_ff   <= 1'b0;
    end else if (buf_pop) begin
      bit_addr_ff <= loaded_ff ? bit_addr_ff + `SCPS_ADDR_W'(1) : bit_addr_ff;
      loaded_ff   <= 1'b1;
      data_ff     <= buf_bit;
    end
  end

  // --------------------------------------------------------------------
  // Tail and chain watch counters
  // --------------------------------------------------------------------
  logic [3:0]  tail_cnt_ff;
  logic [19:0] chain_cnt_ff;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tail_cnt_ff  <= 4'h0;
      chain_cnt_ff <= 20'h0;
    end else begin
      tail_cnt_ff  <= !in_tail ? 4'h0 : tail_cnt_ff + 4'(rise);
      chain_cnt_ff <= !in_casc ? 20'h0 : chain_cnt_ff + 20'(rise);
    end
  end

  // --------------------------------------------------------------------
  // Sequencer
  // --------------------------------------------------------------------
  wire done_step  = in_run & active & loaded_ff & rise & last_bit;
  wire early_stop = drive_clk & loaded_ff & sel_n_s;
  wire chain_over = (chain_cnt_ff == CHAIN_LIMIT);

  always_comb begin
    nxt_state = state_ff;
    if (!oe_s) begin
      nxt_state = scps_pkg::SCPS_RESET;
    end else begin
      case (state_ff)
        scps_pkg::SCPS_RESET: begin
          if (oe_rise) begin
            nxt_state = sel_n_s ? scps_pkg::SCPS_HOLD : scps_pkg::SCPS_RUN;
          end
        end
        scps_pkg::SCPS_HOLD: begin
          if (!sel_n_s) begin
            nxt_state = scps_pkg::SCPS_RUN;
          end
        end
        scps_pkg::SCPS_RUN: begin
          if (done_step) begin
            nxt_state = scps_pkg::SCPS_CASC;
          end else if (early_stop) begin
            nxt_state = scps_pkg::SCPS_ERROR;
          end
        end
        scps_pkg::SCPS_CASC: begin
          if (drive_clk && sel_n_s) begin
            nxt_state = scps_pkg::SCPS_TAIL;
          end else if (drive_clk && chain_over) begin
            nxt_state = scps_pkg::SCPS_ERROR;
          end
        end
        scps_pkg::SCPS_TAIL: begin
          if (rise && tail_cnt_ff == `SCPS_TAIL_LAST) begin
            nxt_state = scps_pkg::SCPS_SLEEP;
          end
        end
        scps_pkg::SCPS_SLEEP: nxt_state = scps_pkg::SCPS_SLEEP;
        scps_pkg::SCPS_ERROR: nxt_state = scps_pkg::SCPS_ERROR;
        default:              nxt_state = scps_pkg::SCPS_RESET;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_ff <= scps_pkg::SCPS_RESET;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // --------------------------------------------------------------------
  // Pin drive
  // --------------------------------------------------------------------
  wire data_drive = in_run & active & loaded_ff;
  wire casc_low   = in_casc | in_tail |
                    (state_ff == scps_pkg::SCPS_SLEEP);

  assign target_serial_in = '{out: data_ff, oe: data_drive};
  assign config_clock     = '{out: osc_ff, oe: drive_clk};
  assign cascade_out_n    = ~casc_low;
  assign target_status_n  = '{out: 1'b0,
                              oe: (state_ff == scps_pkg::SCPS_ERROR)};

endmodule : scps_streamer

`default_nettype wire

// *** test/scps_target_model.sv ***
`timescale 1ns/1ps
`default_nettype none

// --------------------------
// Target configuration port
// --------------------------
module scps_target_model (
  input  wire logic                cfg_clk,
  input  wire logic                clr,
  input  wire scps_pkg::scps_pad_t din,
  input  wire logic                finish,
  output var  logic                done,
  output var  logic [31:0]         n_bits,
  output var  logic [63:0]         bits
);
  logic last_ff;
  logic dat_w;
  logic dat_q;

  // Released line reads back inverted
  assign dat_w = din.oe ? din.out : ~last_ff;
  // Target takes the bit that stood before the clock edge
  assign #2 dat_q = dat_w;
  assign done  = finish;

  always @(din) begin
    if (din.oe) begin
      last_ff = din.out;
    end
  end

  always_ff @(posedge cfg_clk or posedge clr) begin
    if (clr) begin
      n_bits <= 32'h0;
      bits   <= 64'h0;
    end else begin
      bits[n_bits[5:0]] <= dat_q;
      n_bits            <= n_bits + 32'h1;
    end
  end
endmodule : scps_target_model

`default_nettype wire

// *** test/scps_streamer_monitor.sv ***
`timescale 1ns/1ps
`include "scps_regs.svh"
`default_nettype none

// --------------------------
// Port checks
// --------------------------
module scps_streamer_monitor #(
  parameter logic [19:0] CHAIN_LIMIT = `SCPS_CHAIN_LIMIT
) (
  input wire logic                    clk,
  input wire logic                    rst,
  input wire logic                    oe_rst_pin,
  input wire logic                    select_n,
  input wire logic                    protocol_newer,
  input wire logic                    config_clock_in,
  input wire scps_pkg::scps_pad_t     config_clock,
  input wire scps_pkg::scps_pad_t     target_serial_in,
  input wire logic                    cascade_out_n,
  input wire scps_pkg::scps_pad_t     target_status_n,
  input wire logic                    prog_we,
  input wire logic [`SCPS_ADDR_W-1:0] prog_addr,
  input wire logic                    prog_bit
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  AST_RST_FLOAT: assert property (!oe_rst_pin [*4] |-> !target_serial_in.oe && cascade_out_n)
    else $error("data driven during reset");
  AST_RST_CLK_LOW: assert property (!oe_rst_pin [*4] |-> !config_clock.out)
    else $error("clock pin high during reset");
  AST_RST_STATUS: assert property (!oe_rst_pin [*4] |-> !target_status_n.oe)
    else $error("status pulled during reset");
  AST_SEL_FLOAT: assert property (select_n [*4] |-> !target_serial_in.oe)
    else $error("data driven while deselected");
  AST_RUN_DRIVE: assert property ((oe_rst_pin && !select_n) [*8] |-> target_serial_in.oe || !cascade_out_n)
    else $error("data not driven while selected");
  AST_CASC_FLOAT: assert property (!cascade_out_n |-> !target_serial_in.oe)
    else $error("data driven after cascade");
  AST_OSC_PERIOD: assert property ($rose(config_clock.out) |=> !$rose(config_clock.out) [*7])
    else $error("clock rises too close");
  AST_ERR_CAUSE: assert property ($rose(target_status_n.oe) |-> select_n || !cascade_out_n)
    else $error("status pulled without cause");
  AST_ERR_HOLD: assert property (target_status_n.oe && oe_rst_pin |=> target_status_n.oe)
    else $error("status pull dropped");
  AST_POWER_UP: assert property ($fell(rst) |-> !target_serial_in.oe && !config_clock.oe && cascade_out_n)
    else $error("outputs active after power-up");
  AST_MASTER_SEL: assert property ($rose(config_clock.oe) |-> !select_n)
    else $error("clock driven by chain member");
endmodule : scps_streamer_monitor

bind scps_streamer scps_streamer_monitor #(.CHAIN_LIMIT(CHAIN_LIMIT)) i_mon (
  .clk(clk), .rst(rst), .oe_rst_pin(oe_rst_pin), .select_n(select_n),
  .protocol_newer(protocol_newer), .config_clock_in(config_clock_in),
  .config_clock(config_clock), .target_serial_in(target_serial_in),
  .cascade_out_n(cascade_out_n), .target_status_n(target_status_n),
  .prog_we(prog_we), .prog_addr(prog_addr), .prog_bit(prog_bit));

`default_nettype wire

// *** test/tb.sv ***
`timescale 1ns/1ps
`include "scps_regs.svh"
`default_nettype none

// --------------------------
// Streamer testbench
// --------------------------
module tb;
  logic                    clk, rst, oe_pin, sel_drv, newer, slave_clk, finish, clr;
  logic                    prog_we, prog_bit, done, cascade_n;
  logic [`SCPS_ADDR_W-1:0] prog_addr;
  logic [31:0]             n_bits;
  logic [63:0]             bits;
  scps_pkg::scps_pad_t     cfg_clk_pad, data_pad, status_pad;
  int                      bad_count, n_checks;
  wire logic               cfg_clk_w;
  wire logic               select_w;

  assign cfg_clk_w = cfg_clk_pad.oe ? cfg_clk_pad.out : slave_clk;
  assign select_w = sel_drv | done;

  scps_streamer #(.CHAIN_LIMIT(20'h14)) i_dut (
    .clk(clk), .rst(rst), .oe_rst_pin(oe_pin), .select_n(select_w),
    .protocol_newer(newer), .config_clock_in(cfg_clk_w), .config_clock(cfg_clk_pad),
    .target_serial_in(data_pad), .cascade_out_n(cascade_n),
    .target_status_n(status_pad), .prog_we(prog_we), .prog_addr(prog_addr),
    .prog_bit(prog_bit));
  scps_target_model i_target (
    .cfg_clk(cfg_clk_w), .clr(clr), .din(data_pad), .finish(finish), .done(done),
    .n_bits(n_bits), .bits(bits));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  function automatic logic exp_bit(input int a);
    return a[0] ^ a[2] ^ a[5];
  endfunction : exp_bit

  task automatic wait_bits(input int n);
    int k;
    k = 0;
    while (n_bits < n && k < 3000) begin
      step(1);
      k++;
    end
    chk(32'(n_bits >= n), 32'h1);
  endtask : wait_bits

  task automatic cmp_bits(input int n);
    for (int k = 0; k < n; k++) chk(bits[k], exp_bit(k));
  endtask : cmp_bits

  task automatic start(input logic sel, input logic nw);
    oe_pin = 1'b0;
    sel_drv = sel;
    newer = nw;
    clr = 1'b1;
    step(4);
    clr = 1'b0;
    oe_pin = 1'b1;
    step(5);
  endtask : start

  task automatic slave_rises(input int n);
    repeat (n) begin
      slave_clk = 1'b1;
      #40 slave_clk = 1'b0;
      #40;
    end
    step(6);
  endtask : slave_rises

  task automatic t_master;
    logic [31:0] n0;
    start(1'b0, 1'b1);
    newer = 1'b0;
    chk(cfg_clk_pad.oe, 1'b1);
    wait_bits(32);
    cmp_bits(32);
    finish = 1'b1;
    step(12);
    chk(status_pad.oe, 1'b1);
    chk(status_pad.out, 1'b0);
    chk(data_pad.oe, 1'b0);
    n0 = n_bits;
    step(40);
    chk(n_bits, n0);
    oe_pin = 1'b0;
    step(5);
    chk(status_pad.oe, 1'b0);
    chk(cfg_clk_pad.out, 1'b0);
    finish = 1'b0;
    start(1'b0, 1'b1);
    wait_bits(8);
    cmp_bits(8);
  endtask : t_master

  task automatic t_slave;
    start(1'b1, 1'b1);
    chk(cfg_clk_pad.oe, 1'b0);
    slave_rises(4);
    chk(data_pad.oe, 1'b0);
    sel_drv = 1'b0;
    clr = 1'b1;
    step(8);
    clr = 1'b0;
    chk(data_pad.oe, 1'b1);
    slave_rises(16);
    cmp_bits(16);
    chk(cfg_clk_pad.oe, 1'b0);
    start(1'b0, 1'b0);
    chk(cfg_clk_pad.oe, 1'b0);
    slave_rises(8);
    cmp_bits(8);
  endtask : t_slave

  task automatic results;
    if (bad_count == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : results

  initial begin
    {rst, oe_pin, sel_drv, newer, slave_clk, finish, clr} = 7'h40;
    {prog_we, prog_bit, prog_addr} = 18'h0;
    bad_count = 0;
    n_checks = 0;
    step(6);
    rst = 1'b0;
    for (int a = 0; a < 64; a++) begin
      prog_we = 1'b1;
      prog_addr = 16'(a);
      prog_bit = exp_bit(a);
      step(1);
    end
    prog_we = 1'b0;
    step(2);
    chk({data_pad.oe, cfg_clk_pad.oe, status_pad.oe, cascade_n}, 4'h1);
    t_master();
    t_slave();
    results();
  end

  initial begin
    repeat (6000) @(posedge clk);
    bad_count++;
    results();
  end
endmodule : tb

`default_nettype wire
